// *** logic/tws_pkg.sv ***
// Package for the two-wire slave transmitter: register map, fields, status codes, types
package tws_pkg;
    localparam logic [11:0] ADDR_OWN    = 12'h000;
    localparam logic [11:0] ADDR_CTRL   = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_DATA   = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_ST = 12'h010;
    localparam logic [11:0] ADDR_IRQ_MK = 12'h014;

    localparam int CTL_INT  = 7;
    localparam int CTL_ACK  = 6;
    localparam int CTL_STA  = 5;
    localparam int CTL_STO  = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN   = 2;
    localparam int CTL_IE   = 0;
    localparam logic [7:0] CTL_WMASK = 8'h75;

    localparam logic [7:0] OWN_RESET  = 8'h00;
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam logic [7:0] GC_ADDR    = 8'h00;

    localparam logic [7:0] ST_SLA_R   = 8'hA8;
    localparam logic [7:0] ST_ARB_R   = 8'hB0;
    localparam logic [7:0] ST_DATA_A  = 8'hB8;
    localparam logic [7:0] ST_DATA_N  = 8'hC0;
    localparam logic [7:0] ST_LAST_A  = 8'hC8;
    localparam logic [7:0] ST_IDLE    = 8'hF8;
    localparam logic [7:0] ST_BUSERR  = 8'h00;

    localparam int IRQ_FLAG   = 0;
    localparam int IRQ_BUSERR = 1;
    localparam int IRQ_WAKE   = 2;
    localparam int IRQ_W      = 3;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_TX, PH_TX_ACK, PH_IGNORE
    } tws_phase_e;

    // Bus pin group: sampled scl and sda inputs
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_lines_s;
endpackage

// *** logic/tws_slave_tx.sv ***
// Two-wire slave transmitter with APB register access and level interrupt
`timescale 1ns/100ps
module tws_slave_tx
    import tws_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        ARB_LOST,
    input  wire logic        SLEEP_DEEP,
    output logic             WAKE_REQ,
    output logic             START_REQ,
    output logic             IRQ
);
    // Synchronisers
    tws_lines_s s1_q, s2_q, s3_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= '{scl: SCL_IN, sda: SDA_IN};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    wire scl_rise = s2_q.scl & ~s3_q.scl;
    wire scl_fall = ~s2_q.scl & s3_q.scl;
    wire start_c  = s2_q.scl & s3_q.scl & ~s2_q.sda & s3_q.sda;
    wire stop_c   = s2_q.scl & s3_q.scl & s2_q.sda & ~s3_q.sda;

    // Registers
    logic [7:0]       own_q, ctl_q, data_q, stat_q, sh_q;
    logic [IRQ_W-1:0] irq_st_q, irq_mk_q;
    tws_phase_e       ph_q;
    logic [3:0]       bit_q;
    logic             last_q, busy_q, sda_drv_q, ack_pend_q, start_pend_q, wake_q;
    logic             hold_q;

    wire wr    = PSEL & PENABLE & PWRITE;
    wire rd_en = PSEL & ~PWRITE;
    wire hit_own  = PADDR == ADDR_OWN;
    wire hit_ctl  = PADDR == ADDR_CTRL;
    wire hit_stat = PADDR == ADDR_STATUS;
    wire hit_data = PADDR == ADDR_DATA;
    wire hit_ist  = PADDR == ADDR_IRQ_ST;
    wire hit_imk  = PADDR == ADDR_IRQ_MK;
    wire hit_any  = hit_own | hit_ctl | hit_stat | hit_data | hit_ist | hit_imk;

    wire flag     = ctl_q[CTL_INT];
    wire ack_en   = ctl_q[CTL_ACK];
    wire enabled  = ctl_q[CTL_EN];
    // Clearing the flag: write one to its bit
    wire flag_clr = wr & hit_ctl & PWDATA[CTL_INT];
    wire data_wr  = wr & hit_data;

    wire own_hit  = sh_q[7:1] == own_q[7:1];
    wire gc_hit   = own_q[0] & (sh_q == GC_ADDR);
    wire addr_ok  = enabled & ack_en & sh_q[0] & (own_hit | gc_hit);

    // Hardware events that raise the interrupt flag
    logic       ev_set;
    logic [7:0] ev_code;
    logic       buserr;
    assign buserr = (start_c | stop_c) & (ph_q == PH_TX || ph_q == PH_TX_ACK) & (bit_q != 4'h0);
    // After a master ack the ninth fall is already gone, so load while the clock is low
    wire ack_go = (ph_q == PH_ADDR_ACK) ? scl_fall : ~s2_q.scl;

    // Phase sequencer
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ph_q       <= PH_IDLE;
            bit_q      <= 4'h0;
            sh_q       <= 8'h00;
            last_q     <= 1'b0;
            busy_q     <= 1'b0;
            sda_drv_q  <= 1'b0;
            ack_pend_q <= 1'b0;
            hold_q     <= 1'b0;
            ev_set     <= 1'b0;
            ev_code    <= ST_IDLE;
        end else begin
            ev_set <= 1'b0;
            hold_q <= (ph_q == PH_TX_ACK);
            if (stop_c)
                busy_q <= 1'b0;
            else if (start_c)
                busy_q <= 1'b1;
            if (buserr) begin
                ev_set    <= 1'b1;
                ev_code   <= ST_BUSERR;
                ph_q      <= PH_IGNORE;
                sda_drv_q <= 1'b0;
            end else if (start_c) begin
                ph_q      <= enabled ? PH_ADDR : PH_IGNORE;
                bit_q     <= 4'h0;
                sda_drv_q <= 1'b0;
            end else if (stop_c) begin
                ph_q      <= PH_IDLE;
                sda_drv_q <= 1'b0;
            end else begin
                case (ph_q)
                    PH_ADDR: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], s2_q.sda};
                            bit_q <= bit_q + 4'h1;
                        end
                        if (scl_fall && bit_q == 4'h8) begin
                            if (addr_ok) begin
                                sda_drv_q <= 1'b1;
                                ph_q      <= PH_ADDR_ACK;
                                ev_set    <= 1'b1;
                                ev_code   <= ARB_LOST ? ST_ARB_R : ST_SLA_R;
                            end else begin
                                // Write direction and general call belong to receive logic
                                ph_q <= PH_IGNORE;
                            end
                        end
                    end
                    PH_ADDR_ACK, PH_TX_ACK: begin
                        if (!flag && !ack_pend_q && ack_go) begin
                            ph_q      <= PH_TX;
                            bit_q     <= 4'h0;
                            sh_q      <= data_q;
                            // last byte when acknowledge is off
                            last_q    <= ~ack_en;
                            sda_drv_q <= ~data_q[7];
                        end
                        ack_pend_q <= 1'b0;
                    end
                    PH_TX: begin
                        if (scl_fall) begin
                            bit_q <= bit_q + 4'h1;
                            sh_q  <= {sh_q[6:0], 1'b1};
                            sda_drv_q <= (bit_q == 4'h7) ? 1'b0 : ~sh_q[6];
                        end
                        if (scl_rise && bit_q == 4'h8) begin
                            ev_set <= 1'b1;
                            if (s2_q.sda) begin
                                ev_code <= ST_DATA_N;
                                ph_q    <= PH_IGNORE;
                            end else if (last_q) begin
                                ev_code <= ST_LAST_A;
                                ph_q    <= PH_IGNORE;
                            end else begin
                                ev_code    <= ST_DATA_A;
                                ph_q       <= PH_TX_ACK;
                                ack_pend_q <= 1'b1;
                            end
                        end
                    end
                    // all ones to a master reading on
                    PH_IGNORE: sda_drv_q <= 1'b0;
                    PH_IDLE:   sda_drv_q <= 1'b0;
                    default:   ph_q <= PH_IDLE;
                endcase
            end
        end
    end

    // Control, status and data registers
    wire [7:0] ctl_wr = (ctl_q & ~CTL_WMASK) | (PWDATA[7:0] & CTL_WMASK);
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            own_q        <= OWN_RESET;
            ctl_q        <= CTL_RESET;
            data_q       <= DATA_RESET;
            stat_q       <= ST_IDLE;
            start_pend_q <= 1'b0;
            wake_q       <= 1'b0;
        end else begin
            if (wr && hit_own)
                own_q <= PWDATA[7:0];
            if (wr && hit_ctl)
                ctl_q <= {ctl_q[CTL_INT] & ~PWDATA[CTL_INT], ctl_wr[6:0]};
            // Set wins over clear in the same cycle
            if (ev_set) begin
                ctl_q[CTL_INT] <= 1'b1;
                stat_q         <= ev_code;
            end else if (flag_clr) begin
                stat_q <= ST_IDLE;
                if (stat_q == ST_BUSERR)
                    ctl_q[CTL_STO] <= 1'b0;
                if ((stat_q == ST_DATA_N || stat_q == ST_LAST_A) && PWDATA[CTL_STA])
                    start_pend_q <= 1'b1;
            end
            if (start_pend_q && !busy_q)
                start_pend_q <= 1'b0;
            // Data writes while the flag is low collide
            if (data_wr) begin
                if (flag)
                    data_q <= PWDATA[7:0];
                else
                    ctl_q[CTL_WCOL] <= 1'b1;
            end
            // wake on any flag event but a bus error in deep sleep
            if (ev_set && SLEEP_DEEP && ev_code != ST_BUSERR)
                wake_q <= 1'b1;
            else if (flag_clr)
                wake_q <= 1'b0;
        end
    end

    // Interrupt status and mask
    wire [IRQ_W-1:0] irq_ev = {ev_set & SLEEP_DEEP, ev_set & (ev_code == ST_BUSERR), ev_set};
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_st_q <= '0;
            irq_mk_q <= '0;
        end else begin
            irq_st_q <= irq_ev | (irq_st_q & ~((wr && hit_ist) ? PWDATA[IRQ_W-1:0] : '0));
            if (wr && hit_imk)
                irq_mk_q <= PWDATA[IRQ_W-1:0];
        end
    end

    // Read data
    logic [31:0] rd_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B)
            rd_q <= 32'h0000_0000;
        else if (rd_en && !PENABLE)
            rd_q <= hit_own  ? {24'h0, own_q} :
                    hit_ctl  ? {24'h0, ctl_q} :
                    hit_stat ? {24'h0, stat_q} :
                    hit_data ? {24'h0, data_q} :
                    hit_ist  ? {29'h0, irq_st_q} :
                    hit_imk  ? {29'h0, irq_mk_q} : 32'h0000_0000;
    end

    assign PRDATA  = rd_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~hit_any;

    // stretch bus clock
    // Held one cycle past a load from PH_TX_ACK so the first data bit settles before release
    wire stretch = ~s2_q.scl & ((flag & (ph_q == PH_ADDR_ACK)) | (ph_q == PH_TX_ACK) | hold_q);
    assign SCL_OUT   = 1'b0;
    assign SCL_OE    = stretch;
    assign SDA_OUT   = 1'b0;
    assign SDA_OE    = sda_drv_q;
    assign WAKE_REQ  = wake_q;
    assign START_REQ = start_pend_q & ~busy_q;
    assign IRQ       = |(irq_st_q & irq_mk_q) | (flag & ctl_q[CTL_IE]);
endmodule // tws_slave_tx

// *** testbench/tws_master_model.sv ***
// Behavioural bus master reading from the slave
`timescale 1ns/100ps
module tws_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic start();
        sda_oe = 1'b1;
        #100 scl_oe = 1'b1;
    endtask
    task automatic stop();
        #25 sda_oe = 1'b1;
        #75 scl_oe = 1'b0;
        wait (scl === 1'b1);
        #100 sda_oe = 1'b0;
        #100;
    endtask
    // Data moves a quarter after the fall, so it is never seen as a start or stop
    task automatic bit_io(input logic b, output logic r);
        #25 sda_oe = ~b;
        #75 scl_oe = 1'b0;
        wait (scl === 1'b1);
        #50 r = sda;
        #50 scl_oe = 1'b1;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                        output logic as);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ak, as);
    endtask
endmodule // tws_master_model

// *** testbench/tws_slave_tx_assertions.sv ***
// Port-level checker for the two-wire slave transmitter
`timescale 1ns/100ps
module tws_slave_tx_assertions
    import tws_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    input wire logic        SCL_IN,
    input wire logic        SCL_OUT,
    input wire logic        SCL_OE,
    input wire logic        SDA_OUT,
    input wire logic        SDA_OE,
    input wire logic        SLEEP_DEEP,
    input wire logic        WAKE_REQ,
    input wire logic        START_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_grab; $rose(SCL_OE); endsequence
    sequence s_keep; SCL_OE [*4]; endsequence
    sequence s_acc; PSEL && PENABLE && PADDR[1:0] == 2'b00; endsequence
    a_stretch_hold: assert property (s_grab |-> s_keep)
        else $error("clock stretch released early");
    a_lines_low: assert property (!SCL_OUT && !SDA_OUT)
        else $error("line driven high");
    a_wake_stretch: assert property ($rose(WAKE_REQ) |-> ##[0:3] SCL_OE)
        else $error("clock not held after wake");
    a_wake_cause: assert property ($rose(WAKE_REQ) |-> $past(SLEEP_DEEP))
        else $error("wake without sleep");
    a_wake_clear: assert property ($fell(WAKE_REQ) |-> $past(PSEL && PENABLE && PWRITE))
        else $error("wake dropped without write");
    a_start_free: assert property (START_REQ |-> SCL_IN)
        else $error("start request while bus busy");
    a_sda_change: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("data changed with clock high");
    a_unmapped_err: assert property (s_acc |-> PSLVERR == (PADDR > ADDR_IRQ_MK))
        else $error("error response wrong");
    a_unmapped_zero: assert property (s_acc ##0 (!PWRITE && PSLVERR) |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule // tws_slave_tx_assertions
bind tws_slave_tx tws_slave_tx_assertions u_chk (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .SLEEP_DEEP(SLEEP_DEEP), .WAKE_REQ(WAKE_REQ), .START_REQ(START_REQ));

// *** testbench/tws_slave_tx_tb.sv ***
// Register-level bench for the two-wire slave transmitter
`timescale 1ns/100ps
module tws_slave_tx_tb;
    import tws_pkg::*;
    logic        clk, rst_b, psel, penable, pwrite, arb, slp, pready, pslverr, as;
    logic        scl_oe, scl_out, sda_oe, sda_out, wake, sreq, irq, m_scl, m_sda;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  rx;
    wire         scl, sda;
    int          n_errors = 0;
    int          n_checks = 0;
    logic        sreq_seen = 1'b0;
    // Start request is a one-cycle strobe once the bus is free
    always @(posedge clk) if (sreq === 1'b1) sreq_seen <= 1'b1;
    logic [11:0] ra [7] = '{ADDR_OWN, ADDR_CTRL, ADDR_STATUS, ADDR_DATA, ADDR_IRQ_ST,
                            ADDR_IRQ_MK, 12'h020};
    logic [31:0] rv [7] = '{32'(OWN_RESET), 32'(CTL_RESET), 32'(ST_IDLE), 32'(DATA_RESET),
                            32'h0, 32'h0, 32'h0};
    // Open-drain lines with pull-ups
    assign scl = ~((scl_oe & ~scl_out) | m_scl);
    assign sda = ~((sda_oe & ~sda_out) | m_sda);
    tws_slave_tx dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(scl_out), .SCL_OE(scl_oe),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ARB_LOST(arb), .SLEEP_DEEP(slp),
        .WAKE_REQ(wake), .START_REQ(sreq), .IRQ(irq));
    tws_master_model m (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), r, exp);
    endtask
    // Bounded wait; the flag may take a whole byte time to rise
    task automatic wait_irq();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'b1 && n < 4000);
        check("irq", 32'(irq), 32'h1);
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
    endtask
    initial begin
        {psel, penable, pwrite, arb, slp, paddr, pwdata} = '0;
        do_reset();
        for (int i = 0; i < 7; i++) rdc(ra[i], rv[i]);
        wr(ADDR_DATA, 32'h11);
        rdc(ADDR_DATA, 32'hFF);
        rdc(ADDR_CTRL, 32'h08);
        wr(ADDR_OWN, 32'h52);
        rdc(ADDR_OWN, 32'h52);
        wr(ADDR_CTRL, 32'h05);
        m.start();
        m.xfer(8'h53, 1'b1, rx, as);
        m.stop();
        check("no ack", 32'(as), 32'h1);
        wr(ADDR_CTRL, 32'h45);
        fork
            begin
                m.start();
                m.xfer(8'h53, 1'b1, rx, as);
                check("ack", 32'(as), 32'h0);
                m.xfer(8'hFF, 1'b0, rx, as);
                check("d0", 32'(rx), 32'hA5);
                m.xfer(8'hFF, 1'b0, rx, as);
                check("d1", 32'(rx), 32'h3C);
                m.xfer(8'hFF, 1'b1, rx, as);
                check("d2", 32'(rx), 32'hFF);
                m.stop();
            end
            begin
                wait_irq();
                rdc(ADDR_STATUS, 32'(ST_SLA_R));
                wr(ADDR_DATA, 32'hA5);
                wr(ADDR_CTRL, 32'hC5);
                rdc(ADDR_STATUS, 32'(ST_IDLE));
                wait_irq();
                rdc(ADDR_STATUS, 32'(ST_DATA_A));
                wr(ADDR_DATA, 32'h3C);
                wr(ADDR_CTRL, 32'h85);
                wait_irq();
                rdc(ADDR_STATUS, 32'(ST_LAST_A));
                wr(ADDR_CTRL, 32'hC5);
            end
        join
        rdc(ADDR_IRQ_ST, 32'h1);
        wr(ADDR_IRQ_MK, 32'h1);
        @(posedge clk);
        check("irq masked on", 32'(irq), 32'h1);
        wr(ADDR_IRQ_ST, 32'h1);
        @(posedge clk);
        check("irq cleared", 32'(irq), 32'h0);
        wr(ADDR_IRQ_MK, 32'h0);
        fork
            begin
                m.start();
                m.xfer(8'h53, 1'b1, rx, as);
                m.xfer(8'hFF, 1'b1, rx, as);
                check("d3", 32'(rx), 32'h5A);
                m.stop();
            end
            begin
                wait_irq();
                wr(ADDR_DATA, 32'h5A);
                wr(ADDR_CTRL, 32'hC5);
                wait_irq();
                rdc(ADDR_STATUS, 32'(ST_DATA_N));
                wr(ADDR_CTRL, 32'hE5);
            end
        join
        repeat (4) @(posedge clk);
        check("start req", 32'(sreq_seen), 32'h1);
        do_reset();
        @(posedge clk);
        check("start req reset", 32'(sreq), 32'h0);
        wr(ADDR_OWN, 32'h52);
        wr(ADDR_CTRL, 32'h45);
        arb <= 1'b1;
        slp <= 1'b1;
        fork
            begin
                m.start();
                m.xfer(8'h53, 1'b1, rx, as);
                m.xfer(8'hFF, 1'b1, rx, as);
                check("d4", 32'(rx), 32'hC3);
                m.stop();
            end
            begin
                wait_irq();
                rdc(ADDR_STATUS, 32'(ST_ARB_R));
                check("wake", 32'(wake), 32'h1);
                rdc(ADDR_IRQ_ST, 32'h5);
                slp <= 1'b0;
                arb <= 1'b0;
                wr(ADDR_DATA, 32'hC3);
                wr(ADDR_CTRL, 32'h85);
                wait_irq();
                rdc(ADDR_STATUS, 32'(ST_DATA_N));
                wr(ADDR_CTRL, 32'hC5);
            end
        join
        print_verdict();
    end
    // Whole run is well under a millisecond of bus time
    initial begin
        #1000000;
        n_errors++;
        print_verdict();
    end
endmodule // tws_slave_tx_tb
